// [rtl/otsb_regs.vh]
// constants and timing counts for the overtake speed boost controller
// Notes on behaviour
// - second higher cap, limited time per period
// - period starts counting when settings programmed
// - 8, 12, 24 hour periods also refill midnight
// - other periods refill periodically, no midnight refill
// - full-release-full-release-full pedal within five seconds
// - no overspeed within 20 seconds disarms
// - armed overspeed raises cap by extra margin
// - budget consumed only while above normal cap
// - dropping below cap deactivates; rearm needed
// - only foot pedal arms the feature
// - cruise untouched; only off switch cancels it
// - lamp flashes one minute before rampdown
// - rampdown takes five seconds unless speed falls to cap or feature drops out
// - expiry flashes lamp, fault lamp is steady
// - non-shutdown fault keeps feature, lamp steady after
// - stop-engine fault overrides, boost unavailable
// - repeated passes until budget gone, then refill
// - zero budget or zero margin disables feature
// - period 1 to 24 hours, default 8
// - larger of economy bonus and margin applies
`ifndef OTSB_REGS_VH
`define OTSB_REGS_VH
`define OTSB_CLK_HZ 32'h01312d00
`define OTSB_SEC_CYC (`OTSB_CLK_HZ)
`define OTSB_ARM_WIN_S 32'h00000005
`define OTSB_ACCEL_WIN_S 32'h00000014
`define OTSB_WARN_S 16'h003c
`define OTSB_RAMP_S 32'h00000005
`define OTSB_FLASH_HALF_CYC (`OTSB_CLK_HZ / 32'h00000002)
`define OTSB_PERIOD_DEF 5'h08
`define OTSB_PERIOD_MIN 5'h01
`define OTSB_PERIOD_MAX 5'h18
`define OTSB_MARGIN_MAX 8'hfa
`define OTSB_SEC_PER_HOUR 32'h00000e10
`endif

// [rtl/otsb_ctrl.v]
// overtake speed boost controller: arming, budget, refill, lamp, ramp
`include "otsb_regs.vh"
module otsb_ctrl #(
  parameter SEC_CYC = `OTSB_SEC_CYC,
  parameter FLASH_HALF_CYC = `OTSB_FLASH_HALF_CYC
) (
  // clock and reset
  input wire clk_sys,
  input wire srst,
  // settings
  input wire overtake_boost_enable,
  input wire [15:0] overtake_time_budget,
  input wire [4:0] budget_refill_period,
  input wire [7:0] extra_speed_margin,
  input wire settings_load,
  input wire [7:0] economy_bonus,
  // vehicle inputs
  input wire [7:0] road_speed_cap,
  input wire [7:0] vehicle_speed,
  input wire foot_pedal_full,
  input wire foot_pedal_released,
  input wire midnight_tick,
  input wire fault_active,
  input wire stop_engine_fault,
  // outputs
  output reg [7:0] speed_limit_r,
  output reg amber_alert_lamp_r,
  output reg boost_armed_r,
  output reg boost_active_r,
  output reg [15:0] budget_left_r
);
  // main states
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_ARMED = 2'h1;
  localparam [1:0] S_BOOST = 2'h2;
  localparam [1:0] S_RAMP = 2'h3;
  // pedal gesture steps
  localparam [2:0] P_WAIT = 3'h0;
  localparam [2:0] P_FULL1 = 3'h1;
  localparam [2:0] P_REL1 = 3'h2;
  localparam [2:0] P_FULL2 = 3'h3;
  localparam [2:0] P_REL2 = 3'h4;
  localparam [2:0] P_DONE = 3'h5;
  // cycle counts
  localparam [31:0] ARM_CYC = `OTSB_ARM_WIN_S * SEC_CYC;
  localparam [31:0] ACC_CYC = `OTSB_ACCEL_WIN_S * SEC_CYC;
  localparam [31:0] RAMP_CYC = `OTSB_RAMP_S * SEC_CYC;
  localparam [31:0] SEC_M1 = SEC_CYC - 32'h00000001;
  localparam [31:0] FLASH_M1 = FLASH_HALF_CYC - 32'h00000001;

  // registers and their next values
  reg [1:0] st_r;
  reg [1:0] st_nxt;
  reg [2:0] ped_r;
  reg [2:0] ped_nxt;
  reg [31:0] ped_cnt_r;
  reg [31:0] ped_cnt_nxt;
  reg [31:0] tmr_r;
  reg [31:0] tmr_nxt;
  reg [31:0] sec_cnt_r;
  reg [31:0] sec_cnt_nxt;
  reg [31:0] per_sec_r;
  reg [31:0] per_sec_nxt;
  reg [4:0] period_r;
  reg [4:0] period_nxt;
  reg [15:0] budget_left_nxt;
  reg [7:0] ramp_add_r;
  reg [7:0] ramp_add_nxt;
  reg [31:0] flash_cnt_r;
  reg [31:0] flash_cnt_nxt;
  reg flash_r;
  reg flash_nxt;
  reg [7:0] speed_limit_nxt;
  reg amber_alert_lamp_nxt;
  reg boost_armed_nxt;
  reg boost_active_nxt;
  // combinational helpers
  reg [7:0] boost_add;
  reg [8:0] lim_sum;

  // decoded conditions
  wire sec_tick;
  wire [4:0] period_ok;
  wire [31:0] period_sec;
  wire feat_ok;
  wire over_cap;
  wire period_end;
  wire mid_ok;
  wire refill;
  wire [7:0] margin;
  wire warn;
  wire gesture_done;
  wire ped_timeout;
  wire [39:0] ramp_prod;
  wire [39:0] ramp_drop;

  assign sec_tick = (sec_cnt_r == SEC_M1);
  assign period_ok = (budget_refill_period < `OTSB_PERIOD_MIN || budget_refill_period > `OTSB_PERIOD_MAX)
    ? `OTSB_PERIOD_DEF : budget_refill_period;
  assign period_sec = {27'h0000000, period_r} * `OTSB_SEC_PER_HOUR;
  assign feat_ok = overtake_boost_enable && overtake_time_budget != 16'h0000
    && extra_speed_margin != 8'h00 && !stop_engine_fault;
  assign over_cap = vehicle_speed > road_speed_cap;
  assign period_end = sec_tick && (per_sec_r + 32'h00000001 >= period_sec);
  assign mid_ok = (period_r == 5'h08 || period_r == 5'h0c || period_r == 5'h18) && midnight_tick;
  assign refill = period_end || mid_ok;
  assign margin = (extra_speed_margin > `OTSB_MARGIN_MAX) ? `OTSB_MARGIN_MAX : extra_speed_margin;
  assign warn = (st_r == S_BOOST) && (budget_left_r <= `OTSB_WARN_S);
  assign gesture_done = (ped_r == P_DONE);
  assign ped_timeout = (ped_r != P_WAIT) && (ped_cnt_r >= ARM_CYC);
  // fixed length, so step size scales with margin
  assign ramp_prod = {8'h00, tmr_r} * {32'h00000000, margin};
  assign ramp_drop = ramp_prod / {8'h00, RAMP_CYC};

  // one second enable pulse
  always @* begin
    sec_cnt_nxt = sec_cnt_r + 32'h00000001;
    if (sec_tick) begin
      sec_cnt_nxt = 32'h00000000;
    end
  end

  // period timer restarts at programming, not at ignition
  always @* begin
    per_sec_nxt = per_sec_r;
    period_nxt = period_r;
    if (settings_load) begin
      per_sec_nxt = 32'h00000000;
      period_nxt = period_ok;
    end else if (period_end) begin
      per_sec_nxt = 32'h00000000;
    end else if (sec_tick) begin
      per_sec_nxt = per_sec_r + 32'h00000001;
    end
  end

  // pedal gesture from foot pedal only; cruise switches never reach here
  always @* begin
    ped_nxt = ped_r;
    ped_cnt_nxt = ped_cnt_r;
    if (ped_r != P_WAIT) begin
      ped_cnt_nxt = ped_cnt_r + 32'h00000001;
    end
    if (!feat_ok || ped_timeout) begin
      ped_nxt = P_WAIT;
      ped_cnt_nxt = 32'h00000000;
    end else begin
      case (ped_r)
        P_WAIT: begin
          if (foot_pedal_full) begin
            ped_nxt = P_FULL1;
            ped_cnt_nxt = 32'h00000000;
          end
        end
        P_FULL1: begin
          if (foot_pedal_released) begin
            ped_nxt = P_REL1;
          end
        end
        P_REL1: begin
          if (foot_pedal_full) begin
            ped_nxt = P_FULL2;
          end
        end
        P_FULL2: begin
          if (foot_pedal_released) begin
            ped_nxt = P_REL2;
          end
        end
        P_REL2: begin
          if (foot_pedal_full) begin
            ped_nxt = P_DONE;
          end
        end
        default: begin
          ped_nxt = P_WAIT;
          ped_cnt_nxt = 32'h00000000;
        end
      endcase
    end
  end

  // main state machine and budget
  always @* begin
    st_nxt = st_r;
    tmr_nxt = tmr_r;
    ramp_add_nxt = ramp_add_r;
    budget_left_nxt = budget_left_r;
    // a refill and a spend in one cycle: refill wins
    if (settings_load || refill) begin
      budget_left_nxt = overtake_time_budget;
    end else if (st_r == S_BOOST && over_cap && sec_tick && budget_left_r != 16'h0000) begin
      budget_left_nxt = budget_left_r - 16'h0001;
    end
    case (st_r)
      S_IDLE: begin
        tmr_nxt = 32'h00000000;
        if (feat_ok && gesture_done && budget_left_r != 16'h0000) begin
          st_nxt = S_ARMED;
        end
      end
      S_ARMED: begin
        tmr_nxt = tmr_r + 32'h00000001;
        if (!feat_ok || tmr_r >= ACC_CYC) begin
          st_nxt = S_IDLE;
        end else if (over_cap) begin
          st_nxt = S_BOOST;
        end
      end
      S_BOOST: begin
        tmr_nxt = 32'h00000000;
        ramp_add_nxt = margin;
        if (!feat_ok) begin
          st_nxt = S_IDLE;
        end else if (!over_cap) begin
          st_nxt = S_IDLE;
        end else if (budget_left_r == 16'h0000) begin
          st_nxt = S_RAMP;
        end
      end
      S_RAMP: begin
        tmr_nxt = tmr_r + 32'h00000001;
        ramp_add_nxt = margin - ramp_drop[7:0];
        // stop fault or disable ends the ramp at once
        if (tmr_r >= RAMP_CYC || !over_cap || !feat_ok) begin
          st_nxt = S_IDLE;
        end
      end
      default: begin
        st_nxt = S_IDLE;
      end
    endcase
  end

  // limit: cruise never touched here, only the cap moves
  always @* begin
    boost_add = 8'h00;
    if (feat_ok && st_r == S_BOOST) begin
      boost_add = margin;
    end else if (feat_ok && st_r == S_RAMP) begin
      boost_add = ramp_add_r;
    end
    // the two bonuses never add up
    if (economy_bonus > boost_add) begin
      boost_add = economy_bonus;
    end
    lim_sum = {1'h0, road_speed_cap} + {1'h0, boost_add};
    speed_limit_nxt = lim_sum[7:0];
    if (lim_sum[8]) begin
      speed_limit_nxt = 8'hff;
    end
    // flashing wins over steady fault lamp, steady returns after
    amber_alert_lamp_nxt = fault_active;
    if (warn) begin
      amber_alert_lamp_nxt = flash_r;
    end
    boost_armed_nxt = (st_r == S_ARMED);
    // gated like the limit, so flag and cap drop together
    boost_active_nxt = feat_ok && (st_r == S_BOOST || st_r == S_RAMP);
  end

  // flash oscillator, starts lit so the lamp turns on at once
  always @* begin
    flash_cnt_nxt = flash_cnt_r + 32'h00000001;
    flash_nxt = flash_r;
    if (!warn) begin
      flash_cnt_nxt = 32'h00000000;
      flash_nxt = 1'h1;
    end else if (flash_cnt_r == FLASH_M1) begin
      flash_cnt_nxt = 32'h00000000;
      flash_nxt = ~flash_r;
    end
  end

  // all registers, synchronous reset
  always @(posedge clk_sys) begin
    if (srst) begin
      sec_cnt_r <= 32'h00000000;
      per_sec_r <= 32'h00000000;
      period_r <= `OTSB_PERIOD_DEF;
      ped_r <= P_WAIT;
      ped_cnt_r <= 32'h00000000;
      st_r <= S_IDLE;
      tmr_r <= 32'h00000000;
      budget_left_r <= 16'h0000;
      ramp_add_r <= 8'h00;
      flash_cnt_r <= 32'h00000000;
      flash_r <= 1'h1;
      speed_limit_r <= 8'h00;
      amber_alert_lamp_r <= 1'h0;
      boost_armed_r <= 1'h0;
      boost_active_r <= 1'h0;
    end else begin
      sec_cnt_r <= sec_cnt_nxt;
      per_sec_r <= per_sec_nxt;
      period_r <= period_nxt;
      ped_r <= ped_nxt;
      ped_cnt_r <= ped_cnt_nxt;
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      budget_left_r <= budget_left_nxt;
      ramp_add_r <= ramp_add_nxt;
      flash_cnt_r <= flash_cnt_nxt;
      flash_r <= flash_nxt;
      speed_limit_r <= speed_limit_nxt;
      amber_alert_lamp_r <= amber_alert_lamp_nxt;
      boost_armed_r <= boost_armed_nxt;
      boost_active_r <= boost_active_nxt;
    end
  end
endmodule // otsb_ctrl

// [tb/otsb_pedal_model.sv]
// foot pedal and vehicle speed source model
module otsb_pedal_model (
  // clock
  input wire logic clk_sys,
  // pedal switches and speed
  output logic foot_pedal_full = 1'h0,
  output logic foot_pedal_released = 1'h1,
  output logic [7:0] vehicle_speed = 8'h00
);
  timeunit 1ns;
  timeprecision 1ns;
  // foot pedal only: full, released, full, released, full, gap cycles each
  task pump(input int gap);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_sys) {foot_pedal_full, foot_pedal_released} <= i[0] ? 2'h1 : 2'h2;
      repeat (gap - 1) @(posedge clk_sys);
    end
    @(posedge clk_sys) {foot_pedal_full, foot_pedal_released} <= 2'h1;
  endtask
  task speed(input logic [7:0] v);
    @(posedge clk_sys) vehicle_speed <= v;
  endtask
endmodule // otsb_pedal_model

// [tb/otsb_ctrl_properties.sv]
// port assertions for the overtake speed boost controller
module otsb_ctrl_properties #(parameter int FLASH_HALF_CYC = 5) (
  // clock and reset
  input wire clk_sys, srst,
  // inputs
  input wire overtake_boost_enable, fault_active, stop_engine_fault,
  input wire [15:0] overtake_time_budget,
  input wire [7:0] extra_speed_margin, economy_bonus, road_speed_cap, vehicle_speed,
  // outputs
  input wire [7:0] speed_limit_r,
  input wire amber_alert_lamp_r, boost_armed_r, boost_active_r,
  input wire [15:0] budget_left_r
);
  // two half periods plus register slack
  localparam int FW = 2 * FLASH_HALF_CYC + 2;
  wire above = vehicle_speed > road_speed_cap;
  wire [7:0] incr = (extra_speed_margin > economy_bonus) ? extra_speed_margin : economy_bonus;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  a_enable_gates: assert property (!overtake_boost_enable [*4] |-> !boost_armed_r && !boost_active_r)
    else $error("boost state while disabled");
  a_stop_overrides: assert property (stop_engine_fault [*4] |-> !boost_armed_r && !boost_active_r)
    else $error("boost state during stop fault");
  a_arm_refused: assert property ($rose(boost_armed_r) |-> extra_speed_margin != 8'h00 && overtake_time_budget != 16'h0000)
    else $error("armed with zero setting");
  a_active_cause: assert property ($rose(boost_active_r) |-> $past(above))
    else $error("boost active without overspeed");
  a_budget_spend: assert property (budget_left_r < $past(budget_left_r) |-> $past(above) || $past(above, 2) || $past(above, 3))
    else $error("budget spent below cap");
  a_below_ends: assert property ((vehicle_speed < road_speed_cap) [*4] |-> !boost_active_r)
    else $error("boost kept below cap");
  a_raised_cap: assert property ((boost_active_r && budget_left_r != 16'h0000) [*4] |-> speed_limit_r == road_speed_cap + incr)
    else $error("raised cap wrong");
  a_warn_flash: assert property (boost_active_r && budget_left_r <= 16'h003a && budget_left_r > 16'h0002 |-> ##[1:FW] $changed(amber_alert_lamp_r))
    else $error("lamp not flashing in warning");
  a_lamp_steady: assert property ((boost_active_r && budget_left_r > 16'h003e && $stable(fault_active)) [*2] |-> amber_alert_lamp_r == fault_active)
    else $error("lamp not steady outside warning");
  c_armed: cover property ($rose(boost_armed_r));
  c_active: cover property ($rose(boost_active_r));
  c_exhausted: cover property (boost_active_r && budget_left_r == 16'h0000);
endmodule // otsb_ctrl_properties
bind otsb_ctrl otsb_ctrl_properties #(.FLASH_HALF_CYC(FLASH_HALF_CYC)) u_props (.*);

// [tb/otsb_ctrl_tb.sv]
// self-checking bench for the overtake speed boost controller
module otsb_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'h0, srst = 1'h1, overtake_boost_enable = 1'h0, settings_load = 1'h0;
  logic midnight_tick = 1'h0, fault_active = 1'h0, stop_engine_fault = 1'h0;
  logic [15:0] overtake_time_budget = 16'h0050;
  logic [4:0] budget_refill_period = 5'h08;
  logic [7:0] extra_speed_margin = 8'h0a, economy_bonus = 8'h00, road_speed_cap = 8'h64, vehicle_speed;
  logic foot_pedal_full, foot_pedal_released, amber_alert_lamp_r, boost_armed_r, boost_active_r;
  logic [7:0] speed_limit_r;
  logic [15:0] budget_left_r, b0;
  int num_errors = 0, samples_checked = 0;
  logic [4:0] plist [4] = '{5'h08, 5'h0c, 5'h18, 5'h05};
  always #25 clk_sys = ~clk_sys;
  otsb_pedal_model pm (.clk_sys(clk_sys), .foot_pedal_full(foot_pedal_full),
    .foot_pedal_released(foot_pedal_released), .vehicle_speed(vehicle_speed));
  // shortened second so counts finish in a few thousand cycles
  otsb_ctrl #(.SEC_CYC(20), .FLASH_HALF_CYC(5)) dut (.*);
  task cyc(input int n); repeat (n) @(posedge clk_sys); #1; endtask
  task check(input string nm, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task stop_test;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task loadp; @(posedge clk_sys) settings_load <= 1'h1; @(posedge clk_sys) settings_load <= 1'h0; cyc(3); endtask
  task go; pm.speed(8'h00); pm.pump(2); pm.speed(8'h69); endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    srst <= 1'h0;
    loadp();
    check("left", budget_left_r, 16'h0050);
    pm.pump(2);
    cyc(4);
    check("armed", boost_armed_r, 1'h0);
    @(posedge clk_sys) overtake_boost_enable <= 1'h1;
    pm.pump(30);
    cyc(4);
    check("armed", boost_armed_r, 1'h0);
    pm.pump(2);
    cyc(380);
    check("armed", boost_armed_r, 1'h1);
    cyc(40);
    check("armed", boost_armed_r, 1'h0);
    @(posedge clk_sys) economy_bonus <= 8'h0f;
    go();
    cyc(20);
    check("limit", speed_limit_r, 8'h73);
    b0 = budget_left_r;
    cyc(60);
    check("spend", b0 - budget_left_r, 16'h0003);
    pm.speed(8'h5f);
    cyc(6);
    b0 = budget_left_r;
    @(posedge clk_sys) economy_bonus <= 8'h00;
    cyc(100);
    check("left", budget_left_r, b0);
    pm.speed(8'h69);
    cyc(10);
    check("active", boost_active_r, 1'h0);
    check("limit", speed_limit_r, 8'h64);
    @(posedge clk_sys) fault_active <= 1'h1;
    go();
    for (int i = 0; i < 2000 && budget_left_r !== 16'h0000; i++) cyc(1);
    if (budget_left_r !== 16'h0000) begin
      num_errors++;
      stop_test();
    end
    cyc(40);
    check("ramp", speed_limit_r > 8'h64, 1'h1);
    cyc(80);
    check("limit", speed_limit_r, 8'h64);
    check("lamp", amber_alert_lamp_r, 1'h1);
    go();
    cyc(6);
    check("active", boost_active_r, 1'h0);
    @(posedge clk_sys) fault_active <= 1'h0;
    // 8, 12 and 24 hour periods get the midnight top-up, others keep what is left
    foreach (plist[k]) begin
      @(posedge clk_sys) budget_refill_period <= plist[k];
      loadp();
      go();
      cyc(60);
      pm.speed(8'h5f);
      @(posedge clk_sys) midnight_tick <= 1'h1;
      @(posedge clk_sys) midnight_tick <= 1'h0;
      cyc(3);
      check("refill", budget_left_r == 16'h0050, plist[k] != 5'h05);
    end
    go();
    cyc(10);
    @(posedge clk_sys) stop_engine_fault <= 1'h1;
    cyc(4);
    check("active", boost_active_r, 1'h0);
    go();
    cyc(6);
    check("active", boost_active_r, 1'h0);
    @(posedge clk_sys) stop_engine_fault <= 1'h0;
    @(posedge clk_sys) overtake_time_budget <= 16'h0000;
    go();
    cyc(6);
    check("active", boost_active_r, 1'h0);
    @(posedge clk_sys) overtake_time_budget <= 16'h0050;
    extra_speed_margin <= 8'h00;
    go();
    cyc(6);
    check("active", boost_active_r, 1'h0);
    @(posedge clk_sys) extra_speed_margin <= 8'h1e;
    road_speed_cap <= 8'h50;
    loadp();
    go();
    cyc(10);
    check("limit", speed_limit_r, 8'h6e);
    stop_test();
  end
endmodule // otsb_ctrl_tb
